/* verilog/hsc_sequencer.v */
`timescale 1ns/100ps
`include "hsc_regs.vh"

// Summary of operation
// RULE_01 - With both supplies out of lockout a 25 us reset pulse clears the fault latch and all state.
// RULE_02 - Except on return at cooldown end, the switch turns on only after undervoltage and excess input read good for 100 ms unbroken.
// RULE_03 - In current limit the breaker timer runs and a timer-high report trips the switch and latch.
// RULE_04 - After a trip the timer discharges and a timer-low report starts a 100 ms cooldown.
// RULE_05 - With the timer strapped high an internal 2 ms trip delay and 100 ms cooldown are used.
// RULE_06 - After a trip the switch stays off until the fault latch has been cleared.
// RULE_07 - Undervoltage held low for 1 us clears the fault latch while it is still low, without waiting for its release.
// RULE_08 - Fault flag wired to undervoltage makes the latch clear itself for automatic retry.
// RULE_09 - Power good rises only with output feedback and gate drive both good together.
// RULE_10 - Undervoltage low gives a normal turn-off with the slow pull-down.
// RULE_11 - Excess input, a breaker trip or overtemperature also turn the switch off.
// RULE_12 - Power good drops together with the switch at a turn-off, before output feedback falls.
// RULE_13 - Input supply low over 5 us or internal supply low over 1 us forces a fast shutdown.
// RULE_14 - At cooldown end the switch returns only if the latch was cleared, else it stays off.
// RULE_15 - The fault flag is driven low while the latch holds a breaker trip.
// RULE_16 - Every comparator input passes two flip-flops and all delays use a prescaled tick.
// RULE_17 - Fast shutdown wins over a slow turn-off requested in the same cycle.
module hsc_sequencer #(
   parameter integer PRESCALE       = `HSC_US_CYCLES,
   parameter integer POR_TICKS      = `HSC_POR_TICKS,
   parameter integer DEBOUNCE_TICKS = `HSC_DEBOUNCE_TICKS,
   parameter integer CB_TICKS       = `HSC_CB_TICKS,
   parameter integer COOL_TICKS     = `HSC_COOL_TICKS,
   parameter integer VDD_FAST_TICKS = `HSC_VDD_FAST_TICKS,
   parameter integer VCC_FAST_TICKS = `HSC_VCC_FAST_TICKS,
   parameter integer UV_CLR_TICKS   = `HSC_UV_CLR_TICKS
)(
   input  wire i_sys_clk,
   input  wire i_nrst,
   input  wire i_input_supply_lockout,
   input  wire i_internal_supply_lockout,
   input  wire i_internal_supply_low,
   input  wire i_undervoltage_input,
   input  wire i_excess_input_compare,
   input  wire i_output_feedback_input,
   input  wire i_gate_drive_ok,
   input  wire i_timer_low_compare,
   input  wire i_timer_high_compare,
   input  wire i_timer_strapped,
   input  wire i_overtemp,
   input  wire i_current_limit_active,
   output reg  o_switch_on,
   output reg  o_slow_pulldown,
   output reg  o_fast_pulldown,
   output reg  o_timer_charge,
   output reg  o_timer_discharge,
   output reg  o_power_good_output,
   output reg  o_fault_flag_output_n
);

localparam [2:0] S_WAIT  = 3'h0;
localparam [2:0] S_PULSE = 3'h1;
localparam [2:0] S_DEB   = 3'h2;
localparam [2:0] S_ON    = 3'h3;
localparam [2:0] S_TDIS  = 3'h4;
localparam [2:0] S_COOL  = 3'h5;

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

wire [`HSC_NIN-1:0] raw_w;
reg  [`HSC_NIN-1:0] s1_r;
reg  [`HSC_NIN-1:0] s2_r;
reg                 strap_s1_r;
reg                 strap_r;

assign raw_w = {i_current_limit_active, i_overtemp, i_timer_high_compare,
                i_timer_low_compare, i_gate_drive_ok, i_output_feedback_input,
                i_excess_input_compare, i_undervoltage_input,
                i_internal_supply_low, i_internal_supply_lockout,
                i_input_supply_lockout};

genvar g;
generate
   for (g = 0; g < `HSC_NIN; g = g + 1)
   begin : g_sync
      always @(posedge i_sys_clk or negedge i_nrst)
      begin
         if (!i_nrst)
         begin
            // lockouts start asserted so the sequencer cannot leave wait early
            s1_r[g] <= (g == `HSC_IN_VDD_LOCK) || (g == `HSC_IN_VCC_LOCK);
            s2_r[g] <= (g == `HSC_IN_VDD_LOCK) || (g == `HSC_IN_VCC_LOCK);
         end
         else
         begin
            s1_r[g] <= raw_w[g]; // RULE_16
            s2_r[g] <= s1_r[g];  // RULE_16
         end
      end
   end
endgenerate

// strap caught by a clocked process, never at reset
always @(posedge i_sys_clk or negedge i_nrst)
begin
   if (!i_nrst)
   begin
      strap_s1_r <= 1'b0;
      strap_r    <= 1'b0;
   end
   else
   begin
      strap_s1_r <= i_timer_strapped;
      strap_r    <= strap_s1_r;
   end
end

wire vdd_lock = s2_r[`HSC_IN_VDD_LOCK];
wire vcc_lock = s2_r[`HSC_IN_VCC_LOCK];
wire vcc_low  = s2_r[`HSC_IN_VCC_LOW];
wire uv_ok    = s2_r[`HSC_IN_UV];
wire ov       = s2_r[`HSC_IN_OV];
wire fb_ok    = s2_r[`HSC_IN_FB];
wire gate_ok  = s2_r[`HSC_IN_GATE_OK];
wire tm_low   = s2_r[`HSC_IN_TM_LOW];
wire tm_high  = s2_r[`HSC_IN_TM_HIGH];
wire otemp    = s2_r[`HSC_IN_OVERTEMP];
wire ilim     = s2_r[`HSC_IN_ILIM];

////////////////////////////////////////////////////////////////////////////////
// 1 us tick prescaler

reg  [15:0] pre_r;
wire        tick = ({16'h0000, pre_r} == PRESCALE - 1); // RULE_16

always @(posedge i_sys_clk or negedge i_nrst)
begin
   if (!i_nrst)
      pre_r <= 16'h0000;
   else if (tick)
      pre_r <= 16'h0000;
   else
      pre_r <= pre_r + 16'h0001;
end

////////////////////////////////////////////////////////////////////////////////
// supply glitch filters and undervoltage retry detector

reg  [7:0] vdd_cnt_r;
reg  [7:0] vcc_cnt_r;
reg  [7:0] uvl_cnt_r;
reg        in_por_r;

wire fast_req = ({24'h000000, vdd_cnt_r} > VDD_FAST_TICKS) |
                ({24'h000000, vcc_cnt_r} > VCC_FAST_TICKS); // RULE_13
wire vdd_sat  = (vdd_cnt_r == 8'hFF);
wire vcc_sat  = (vcc_cnt_r == 8'hFF);
wire uvl_full = ({24'h000000, uvl_cnt_r} >= UV_CLR_TICKS);
wire uv_clr   = !uv_ok & tick & !uvl_full & !in_por_r &
                ({24'h000000, uvl_cnt_r} == UV_CLR_TICKS - 1); // RULE_07 RULE_08

always @(posedge i_sys_clk or negedge i_nrst)
begin
   if (!i_nrst)
   begin
      vdd_cnt_r <= 8'h00;
      vcc_cnt_r <= 8'h00;
      uvl_cnt_r <= 8'h00;
   end
   else
   begin
      if (!vdd_lock)
         vdd_cnt_r <= 8'h00;
      else if (tick & !vdd_sat)
         vdd_cnt_r <= vdd_cnt_r + 8'h01;
      if (!vcc_low)
         vcc_cnt_r <= 8'h00;
      else if (tick & !vcc_sat)
         vcc_cnt_r <= vcc_cnt_r + 8'h01;
      if (uv_ok | in_por_r)
         uvl_cnt_r <= 8'h00;
      else if (tick & !uvl_full)
         uvl_cnt_r <= uvl_cnt_r + 8'h01;
   end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

reg  [2:0]  state_r;
reg  [2:0]  state_nxt;
reg  [16:0] cnt_r;
reg  [16:0] cnt_nxt;
reg         latch_r;
reg         latch_nxt;
reg         trip;
wire [31:0] cnt_x   = {15'h0000, cnt_r};
wire        in_ok   = uv_ok & !ov;
wire [16:0] cnt_inc = tick ? cnt_r + 17'h00001 : cnt_r;

always @*
begin
   state_nxt = state_r;
   cnt_nxt   = cnt_r;
   trip      = 1'b0;
   case (state_r)
      S_WAIT:
      begin
         cnt_nxt = 17'h00000;
         if (!vdd_lock & !vcc_lock & !fast_req)
            state_nxt = S_PULSE;
      end
      S_PULSE:
      begin
         cnt_nxt = cnt_inc;
         if (tick & (cnt_x == POR_TICKS - 1)) // RULE_01
         begin
            state_nxt = S_DEB;
            cnt_nxt   = 17'h00000;
         end
      end
      S_DEB:
      begin
         if (!in_ok | otemp | latch_r) // RULE_02 RULE_06 RULE_11
            cnt_nxt = 17'h00000;
         else if (tick & (cnt_x == DEBOUNCE_TICKS - 1)) // RULE_02
         begin
            state_nxt = S_ON;
            cnt_nxt   = 17'h00000;
         end
         else
            cnt_nxt = cnt_inc;
      end
      S_ON:
      begin
         cnt_nxt = (ilim & strap_r) ? cnt_inc : 17'h00000;
         if (strap_r)
            trip = ilim & tick & (cnt_x == CB_TICKS - 1); // RULE_05
         else
            trip = ilim & tm_high; // RULE_03
         if (trip)
         begin
            state_nxt = strap_r ? S_COOL : S_TDIS; // RULE_05 RULE_11
            cnt_nxt   = 17'h00000;
         end
         else if (!uv_ok | ov | otemp) // RULE_10 RULE_11
         begin
            state_nxt = S_DEB;
            cnt_nxt   = 17'h00000;
         end
      end
      S_TDIS:
      begin
         cnt_nxt = 17'h00000;
         if (tm_low) // RULE_04
            state_nxt = S_COOL;
      end
      S_COOL:
      begin
         cnt_nxt = cnt_inc;
         if (tick & (cnt_x == COOL_TICKS - 1)) // RULE_04 RULE_05
         begin
            cnt_nxt = 17'h00000;
            if (!latch_r & in_ok & !otemp)
               state_nxt = S_ON; // RULE_14
            else
               state_nxt = S_DEB; // RULE_14
         end
      end
      default:
      begin
         state_nxt = S_WAIT;
         cnt_nxt   = 17'h00000;
      end
   endcase
   if (fast_req) // RULE_13
   begin
      state_nxt = S_WAIT;
      cnt_nxt   = 17'h00000;
   end
   // trip sets over any clear in the same cycle
   if (trip)
      latch_nxt = 1'b1; // RULE_03
   else if (state_r == S_PULSE)
      latch_nxt = 1'b0; // RULE_01
   else if (uv_clr)
      latch_nxt = 1'b0; // RULE_07 RULE_08
   else
      latch_nxt = latch_r; // RULE_06
end

wire on_nxt = (state_nxt == S_ON);

always @(posedge i_sys_clk or negedge i_nrst)
begin
   if (!i_nrst)
   begin
      state_r               <= S_WAIT;
      cnt_r                 <= 17'h00000;
      latch_r               <= 1'b0;
      in_por_r              <= 1'b1;
      o_switch_on           <= 1'b0;
      o_slow_pulldown       <= 1'b1;
      o_fast_pulldown       <= 1'b0;
      o_timer_charge        <= 1'b0;
      o_timer_discharge     <= 1'b0;
      o_power_good_output   <= 1'b0;
      o_fault_flag_output_n <= 1'b1;
   end
   else
   begin
      state_r               <= state_nxt;
      cnt_r                 <= cnt_nxt;
      latch_r               <= latch_nxt;
      in_por_r              <= (state_nxt == S_WAIT) | (state_nxt == S_PULSE);
      o_switch_on           <= on_nxt;
      o_fast_pulldown       <= fast_req;                     // RULE_13 RULE_17
      o_slow_pulldown       <= !on_nxt & !fast_req;          // RULE_10 RULE_17
      o_timer_charge        <= on_nxt & ilim & !strap_r;     // RULE_03
      o_timer_discharge     <= (state_nxt == S_TDIS);        // RULE_04
      o_power_good_output   <= on_nxt & fb_ok & gate_ok;     // RULE_09 RULE_12
      o_fault_flag_output_n <= !latch_nxt;                   // RULE_15
   end
end

endmodule

/* common/hsc_regs.vh */
`ifndef HSC_REGS_VH
`define HSC_REGS_VH

// clock and base tick
`define HSC_CLK_PERIOD_NS 10
`define HSC_US_CYCLES     (1000 / `HSC_CLK_PERIOD_NS)

// documented times
`define HSC_T_POR_US      25
`define HSC_T_DEBOUNCE_MS 100
`define HSC_T_CB_MS       2
`define HSC_T_COOL_MS     100
`define HSC_T_VDD_FAST_US 5
`define HSC_T_VCC_FAST_US 1
`define HSC_T_UV_CLR_US   1

// times as counts of 1 us ticks
`define HSC_POR_TICKS      (`HSC_T_POR_US)
`define HSC_DEBOUNCE_TICKS (`HSC_T_DEBOUNCE_MS * 1000)
`define HSC_CB_TICKS       (`HSC_T_CB_MS * 1000)
`define HSC_COOL_TICKS     (`HSC_T_COOL_MS * 1000)
`define HSC_VDD_FAST_TICKS (`HSC_T_VDD_FAST_US)
`define HSC_VCC_FAST_TICKS (`HSC_T_VCC_FAST_US)
`define HSC_UV_CLR_TICKS   (`HSC_T_UV_CLR_US)

// synchroniser bit positions
`define HSC_NIN          11
`define HSC_IN_VDD_LOCK  0
`define HSC_IN_VCC_LOCK  1
`define HSC_IN_VCC_LOW   2
`define HSC_IN_UV        3
`define HSC_IN_OV        4
`define HSC_IN_FB        5
`define HSC_IN_GATE_OK   6
`define HSC_IN_TM_LOW    7
`define HSC_IN_TM_HIGH   8
`define HSC_IN_OVERTEMP  9
`define HSC_IN_ILIM      10

`endif

/* tb/hsc_sequencer_sva.sv */
`timescale 1ns/100ps
module hsc_sequencer_sva (
   input wire i_sys_clk,
   input wire i_nrst,
   input wire i_undervoltage_input,
   input wire i_excess_input_compare,
   input wire i_output_feedback_input,
   input wire i_gate_drive_ok,
   input wire i_overtemp,
   input wire i_current_limit_active,
   input wire o_switch_on,
   input wire o_slow_pulldown,
   input wire o_fast_pulldown,
   input wire o_timer_charge,
   input wire o_timer_discharge,
   input wire o_power_good_output,
   input wire o_fault_flag_output_n
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   a_fast_wins: assert property (o_fast_pulldown |-> !o_slow_pulldown && !o_switch_on)
      else $error("fast with slow or on");
   a_uv_off: assert property (!i_undervoltage_input [*4] |-> !o_switch_on)
      else $error("on with uv low");
   a_ov_off: assert property (i_excess_input_compare [*4] |-> !o_switch_on)
      else $error("on with excess input");
   a_ot_off: assert property (i_overtemp [*4] |-> !o_switch_on)
      else $error("on with overtemp");
   a_pg_cause: assert property (o_power_good_output |->
      $past(i_gate_drive_ok, 3) && $past(i_output_feedback_input, 3))
      else $error("pg without cause");
   a_pg_fb: assert property (!i_output_feedback_input [*4] |-> !o_power_good_output)
      else $error("pg with feedback low");
   a_pg_off: assert property (!o_switch_on [*2] |-> !o_power_good_output)
      else $error("pg with switch off");
   a_latch_off: assert property (!o_fault_flag_output_n |-> !o_switch_on)
      else $error("on while latched");
   a_trip_on: assert property ($fell(o_fault_flag_output_n) |-> $past(o_switch_on))
      else $error("fault without trip");
   a_charge_lim: assert property (o_timer_charge |-> $past(i_current_limit_active, 3))
      else $error("charge without limit");
   a_dis_trip: assert property ($rose(o_timer_discharge) |-> !o_fault_flag_output_n)
      else $error("discharge without trip");
endmodule
bind hsc_sequencer hsc_sequencer_sva u_sva (.*);

/* tb/hsc_far_side.sv */
`timescale 1ns/100ps
module hsc_far_side (
   input  wire i_clk,
   input  wire i_on,
   input  wire i_chg,
   input  wire i_dis,
   input  wire i_flt_n,
   input  wire i_auto,
   input  wire i_uv,
   output wire o_fb,
   output wire o_gok,
   output wire o_tlo,
   output wire o_thi,
   output wire o_uv
);
   reg [3:0] d_r = 4'H0;
   reg [5:0] t_r = 6'H00;
   always @(posedge i_clk)
   begin
      d_r <= {d_r[2:0], i_on};
      t_r <= t_r + {5'H00, i_chg & ~&t_r} - {5'H00, i_dis & |t_r};
   end
   assign o_fb  = d_r[3];
   assign o_gok = d_r[1];
   assign o_thi = t_r > 6'H28;
   assign o_tlo = t_r < 6'H05;
   assign o_uv  = i_uv & (~i_auto | i_flt_n);
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   reg     clk = 1'H0, nrst = 1'H0, vl = 1'H1, il = 1'H1, lo = 1'H0, uvb = 1'H1;
   reg     ov = 1'H0, st = 1'H0, ot = 1'H0, ilim = 1'H0, auto = 1'H0;
   wire    on, slow, fast, chg, dis, pg, fn, fb, gok, tlo, thi, uv;
   integer mismatches = 0, num_checks = 0, n, k;
   hsc_sequencer #(.PRESCALE(4), .POR_TICKS(5), .DEBOUNCE_TICKS(20), .CB_TICKS(10),
      .COOL_TICKS(20)) dut (.i_sys_clk(clk), .i_nrst(nrst), .i_input_supply_lockout(vl),
      .i_internal_supply_lockout(il), .i_internal_supply_low(lo), .i_undervoltage_input(uv),
      .i_excess_input_compare(ov), .i_output_feedback_input(fb), .i_gate_drive_ok(gok),
      .i_timer_low_compare(tlo), .i_timer_high_compare(thi), .i_timer_strapped(st),
      .i_overtemp(ot), .i_current_limit_active(ilim), .o_switch_on(on),
      .o_slow_pulldown(slow), .o_fast_pulldown(fast), .o_timer_charge(chg),
      .o_timer_discharge(dis), .o_power_good_output(pg), .o_fault_flag_output_n(fn));
   hsc_far_side far (.i_clk(clk), .i_on(on), .i_chg(chg), .i_dis(dis), .i_flt_n(fn),
      .i_auto(auto), .i_uv(uvb), .o_fb(fb), .o_gok(gok), .o_tlo(tlo), .o_thi(thi), .o_uv(uv));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input integer c);
      repeat (c) @(negedge clk);
   endtask
   // waits for the switch level, n counts cycles
   task won(input v);
      n = 0;
      while (on !== v && n < 400)
      begin
         @(negedge clk);
         n = n + 1;
      end
      chk(on, v);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_power;
      cyc(20);
      chk({on, slow, fast, chg, dis, pg, fn}, 7'H21);
      vl = 1'H0;
      il = 1'H0;
      won(1'H1);
      chk(n >= 90 && n <= 125, 1);
   endtask
   task t_pg;
      cyc(12);
      chk(pg, 1);
      uvb = 1'H0;
      cyc(8);
      chk({on, slow, pg}, 3'H2);
   endtask
   task t_bounce;
      uvb = 1'H1;
      cyc(40);
      uvb = 1'H0;
      cyc(8);
      uvb = 1'H1;
      won(1'H1);
      chk(n >= 70, 1);
   endtask
   task t_faults;
      for (k = 0; k < 2; k = k + 1)
      begin
         {ov, ot} = (k == 0) ? 2'H2 : 2'H1;
         cyc(120);
         chk({on, slow, pg}, 3'H2);
         {ov, ot} = 2'H0;
         won(1'H1);
      end
   endtask
   task t_latch;
      ilim = 1'H1;
      cyc(8);
      chk(chg, 1);
      won(1'H0);
      chk({fn, dis}, 2'H1);
      ilim = 1'H0;
      cyc(300);
      chk({on, fn}, 2'H0);
      uvb = 1'H0;
      cyc(8);
      chk(fn, 1);
      uvb = 1'H1;
      won(1'H1);
   endtask
   task t_auto;
      st = 1'H1;
      auto = 1'H1;
      cyc(4);
      ilim = 1'H1;
      cyc(20);
      chk(chg, 0);
      won(1'H0);
      chk({fn, n >= 14 && n <= 32}, 2'H1);
      ilim = 1'H0;
      won(1'H1);
      chk(n >= 70, 1);
      st = 1'H0;
      auto = 1'H0;
   endtask
   task t_fast;
      vl = 1'H1;
      cyc(8);
      vl = 1'H0;
      cyc(8);
      chk({on, fast}, 2'H2);
      lo = 1'H1;
      cyc(16);
      chk({on, slow, fast}, 3'H1);
      lo = 1'H0;
      won(1'H1);
      vl = 1'H1;
      cyc(40);
      chk(fast, 1);
      vl = 1'H0;
      won(1'H1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #5 clk = ~clk;
   end
   initial
   begin
      #100000;
      mismatches = mismatches + 1;
      stop_test;
   end
   initial
   begin
      cyc(6);
      nrst = 1'H1;
      t_power;
      t_pg;
      t_bounce;
      t_faults;
      t_latch;
      t_auto;
      t_fast;
      stop_test;
   end
endmodule
